//--- converter_startup_pkg.sv
// constants, register layout and carrier types shared by the startup sequencer
// assumes the converter takes 24-bit write frames: read flag, 15-bit address, 8-bit data
package converter_startup_pkg;

  // apb register byte offsets of the controller itself
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET  = 8'h08;

  // control register fields
  localparam int CONTROL_POWER_BIT = 0;
  localparam int CONTROL_START_BIT = 1;

  // converter register addresses, plain defaults to be matched to the real map
  localparam logic [14:0] DEV_SOFT_RESET_ADDR  = 15'h0000;
  localparam logic [14:0] DEV_LINK_ENABLE_ADDR = 15'h0200;
  localparam logic [14:0] DEV_CAL_ENABLE_ADDR  = 15'h0061;
  localparam logic [14:0] DEV_LINK_MODE_ADDR   = 15'h0201;
  localparam logic [14:0] DEV_MULTIFRAME_ADDR  = 15'h0202;
  localparam logic [14:0] DEV_SYNC_SOURCE_ADDR = 15'h0203;
  localparam logic [14:0] DEV_CAL_CONFIG_ADDR  = 15'h0062;
  localparam logic [14:0] DEV_OVERRANGE_ADDR   = 15'h0213;
  localparam logic [14:0] DEV_CAL_TRIGGER_ADDR = 15'h006C;

  // data bytes that switch a one-bit control
  localparam logic [7:0] BIT_OFF         = 8'h00;
  localparam logic [7:0] BIT_ON          = 8'h01;
  localparam logic [7:0] SOFT_RESET_DATA = 8'h01;

  // sequence steps, one device write each, in issue order
  localparam logic [3:0] STEP_SOFT_RESET = 4'h0;
  localparam logic [3:0] STEP_LINK_OFF   = 4'h1;
  localparam logic [3:0] STEP_CAL_OFF    = 4'h2;
  localparam logic [3:0] STEP_LINK_MODE  = 4'h3;
  localparam logic [3:0] STEP_MULTIFRAME = 4'h4;
  localparam logic [3:0] STEP_SYNC_SRC   = 4'h5;
  localparam logic [3:0] STEP_CAL_CONFIG = 4'h6;
  localparam logic [3:0] STEP_CAL_ON     = 4'h7;
  localparam logic [3:0] STEP_OVERRANGE  = 4'h8;
  localparam logic [3:0] STEP_LINK_ON    = 4'h9;
  localparam logic [3:0] STEP_TRIG_LOW   = 4'hA;
  localparam logic [3:0] STEP_TRIG_HIGH  = 4'hB;

  // timing: soft reset settle time, 8 ns clock
  localparam int CLK_PERIOD_PS       = 8000;
  localparam int SOFT_RESET_WAIT_NS  = 1000;
  localparam int SOFT_RESET_CYCLES   = (SOFT_RESET_WAIT_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
  localparam int SPI_HALF_PERIOD     = 4;

  // one frame to the converter serial port
  typedef struct packed {
    logic        read;
    logic [14:0] addr;
    logic [7:0]  data;
  } spi_frame_t;

  // software configuration word, bits 22:0 of the config register
  typedef struct packed {
    logic [2:0] ovr_setting;
    logic       ovr_enable;
    logic       cal_offset;
    logic       cal_background;
    logic       sync_from_timestamp;
    logic [7:0] multiframe_length_minus_one;
    logic [2:0] pad;
    logic [4:0] link_mode_select;
  } config_t;

  localparam config_t CONFIG_RESET = 23'h01F000;

endpackage

//--- spi_frame_writer.sv
// serial writer: shifts one frame out msb first, mode 0, chip select low
// assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps

module spi_frame_writer
  import converter_startup_pkg::*;
#(
  parameter int HALF_PERIOD = SPI_HALF_PERIOD,
  parameter int FRAME_BITS  = 24
)
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire logic [FRAME_BITS-1:0] frame,
  output logic                       busy,
  output logic                       done,
  output logic                       sclk,
  output logic                       cs_n,
  output logic                       mosi
);

  logic [FRAME_BITS-1:0] shift;
  logic [7:0]            bits_left;
  logic [7:0]            phase;

  // half-period tick and the falling edge that ends each bit
  wire half_tick = busy && (phase == 8'(HALF_PERIOD - 1));
  wire fall_now  = half_tick && sclk;
  wire last_bit  = (bits_left == 8'h01);

  // shifter: data changes on sclk fall so the device samples it on rise
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      busy      <= 1'b0;
      done      <= 1'b0;
      sclk      <= 1'b0;
      cs_n      <= 1'b1;
      mosi      <= 1'b0;
      shift     <= '0;
      bits_left <= 8'h00;
      phase     <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy      <= 1'b1;
        cs_n      <= 1'b0;
        shift     <= frame;
        mosi      <= frame[FRAME_BITS-1];
        bits_left <= 8'(FRAME_BITS);
        phase     <= 8'h00;
      end
      else if (busy)
      begin
        phase <= half_tick ? 8'h00 : phase + 8'h01;
        if (half_tick)
          sclk <= !sclk;
        if (fall_now)
        begin
          bits_left <= bits_left - 8'h01;
          shift     <= {shift[FRAME_BITS-2:0], 1'b0};
          mosi      <= shift[FRAME_BITS-2];
          if (last_bit)
          begin
            busy <= 1'b0;
            cs_n <= 1'b1;
            done <= 1'b1; // frame fully shifted, the write is complete
          end
        end
      end
    end
  end

  // chip select stays low for the whole frame
  cs_held_a: assert property (@(posedge clk) disable iff (reset)
    busy |-> !cs_n) else $error("chip select high inside a frame");

  // a finished frame always releases chip select on the same edge
  done_release_a: assert property (@(posedge clk) disable iff (reset)
    done |-> cs_n && !busy && $past(busy)) else $error("done without frame end");

endmodule // spi_frame_writer

//--- converter_startup_sequencer.sv
// host-side startup sequencer for an rf-sampling converter with a serial output link
// assumes software on apb, device on a write-only serial port, power-good pins async
// Notes on behaviour
// - configuration waits until the device clock is reported stable
// - soft reset written first, then at least one microsecond wait
// - link enable cleared before any link setting is changed
// - calibration enable cleared right after the link is halted
// - link mode select written while both machines are halted
// - multiframe length written as frames minus one, after link mode
// - sync source chosen: single-ended sync input or timestamp pair
// - calibration mode and offset calibration written before calibration enable
// - calibration enable set after its settings are written
// - overrange enable and settings written after calibration enable
// - link enable set last before the calibration trigger
// - calibration trigger written zero then one to start calibration
// - core 1.1 V regulator enabled only while 1.9 V power good holds
// - core 1.1 V regulator dropped as soon as 1.9 V loses regulation
// - all configuration goes through the device serial register port
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps

module converter_startup_sequencer
  import converter_startup_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // supply pins
  input  wire logic        analog_1v9_rail_good,
  input  wire logic        core_1v1_rails_good,
  input  wire logic        device_clock_stable,
  output logic             analog_1v9_rail_enable,
  output logic             core_1v1_rails_enable,
  // device serial register port
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_mosi
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT_CLOCK,
    S_SEND,
    S_WAIT_SPI,
    S_HOLD,
    S_DONE
  } seq_state_t;

  seq_state_t state;
  config_t    cfg;
  logic       power_request;
  logic       done_flag;
  logic [3:0] step;
  logic [7:0] hold_count;
  logic       spi_start;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic       spi_busy;
  logic       spi_done;
  logic       sclk_int;
  logic       cs_n_int;
  logic       mosi_int;

  // pin synchronisers: first stage feeds only the second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= {device_clock_stable, core_1v1_rails_good, analog_1v9_rail_good};
      pin_sync <= pin_meta;
    end
  end

  wire analog_good = pin_sync[0];
  wire core_good   = pin_sync[1];
  wire clock_good  = pin_sync[2];

  // apb decode; two-cycle access phase so every output comes from a flop
  wire apb_access  = psel && penable;
  wire apb_commit  = apb_access && pready;
  wire hit_control = (paddr == CONTROL_OFFSET);
  wire hit_config  = (paddr == CONFIG_OFFSET);
  wire hit_status  = (paddr == STATUS_OFFSET);
  wire hit_any     = hit_control || hit_config || hit_status;
  wire wr_control  = apb_commit && pwrite && hit_control;
  wire wr_config   = apb_commit && pwrite && hit_config;
  wire start_req   = wr_control && pwdata[CONTROL_START_BIT];
  wire busy        = (state != S_IDLE) && (state != S_DONE);

  wire [31:0] status_word = {20'h00000, step, 2'b00, core_1v1_rails_enable, clock_good,
                             core_good, analog_good, done_flag, busy};
  wire [31:0] read_mux = hit_control ? {31'h00000000, power_request} :
                         hit_config  ? {9'h000, cfg} :
                         hit_status  ? status_word : 32'h00000000;

  // bus answer: pready one cycle into the access phase, error on unmapped offsets
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready && !hit_any;
      prdata  <= (apb_access && !pready && !pwrite) ? read_mux : 32'h00000000;
    end
  end

  // software registers; config is frozen while a sequence runs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      power_request <= 1'b0;
      cfg           <= CONFIG_RESET;
    end
    else
    begin
      if (wr_control)
        power_request <= pwdata[CONTROL_POWER_BIT];
      if (wr_config && !busy)
        cfg <= config_t'(pwdata[22:0]);
    end
  end

  // supply sequencing: core follows the synchronised 1.9 V good level
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      analog_1v9_rail_enable <= 1'b0;
      core_1v1_rails_enable  <= 1'b0;
    end
    else
    begin
      analog_1v9_rail_enable <= power_request;
      core_1v1_rails_enable  <= power_request && analog_good;
    end
  end

  // frame for each step; step order is the issue order of device writes
  function automatic spi_frame_t step_frame(input logic [3:0] s, input config_t c);
    spi_frame_t f;
    f.read = 1'b0;
    unique case (s)
      STEP_SOFT_RESET: {f.addr, f.data} = {DEV_SOFT_RESET_ADDR, SOFT_RESET_DATA};
      STEP_LINK_OFF:   {f.addr, f.data} = {DEV_LINK_ENABLE_ADDR, BIT_OFF};
      STEP_CAL_OFF:    {f.addr, f.data} = {DEV_CAL_ENABLE_ADDR, BIT_OFF};
      STEP_LINK_MODE:  {f.addr, f.data} = {DEV_LINK_MODE_ADDR,
                                           {3'h0, c.link_mode_select}};
      STEP_MULTIFRAME: {f.addr, f.data} = {DEV_MULTIFRAME_ADDR,
                                           c.multiframe_length_minus_one};
      STEP_SYNC_SRC:   {f.addr, f.data} = {DEV_SYNC_SOURCE_ADDR,
                                           {7'h00, c.sync_from_timestamp}};
      STEP_CAL_CONFIG: {f.addr, f.data} = {DEV_CAL_CONFIG_ADDR,
                                           {6'h00, c.cal_offset, c.cal_background}};
      STEP_CAL_ON:     {f.addr, f.data} = {DEV_CAL_ENABLE_ADDR, BIT_ON};
      STEP_OVERRANGE:  {f.addr, f.data} = {DEV_OVERRANGE_ADDR,
                                           {4'h0, c.ovr_setting, c.ovr_enable}};
      STEP_LINK_ON:    {f.addr, f.data} = {DEV_LINK_ENABLE_ADDR, BIT_ON};
      STEP_TRIG_LOW:   {f.addr, f.data} = {DEV_CAL_TRIGGER_ADDR, BIT_OFF};
      STEP_TRIG_HIGH:  {f.addr, f.data} = {DEV_CAL_TRIGGER_ADDR, BIT_ON};
      default:         {f.addr, f.data} = {15'h0000, BIT_OFF};
    endcase
    return f;
  endfunction

  wire spi_frame_t cur_frame = step_frame(step, cfg);
  wire             hold_over = (hold_count == 8'(SOFT_RESET_CYCLES - 1));
  wire             last_step = (step == STEP_TRIG_HIGH);

  // sequencer: one write at a time, next one only after the frame is done
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state      <= S_IDLE;
      step       <= STEP_SOFT_RESET;
      hold_count <= 8'h00;
      spi_start  <= 1'b0;
      done_flag  <= 1'b0;
    end
    else
    begin
      spi_start <= 1'b0;
      unique case (state)
        S_IDLE, S_DONE:
          if (start_req && core_good)
          begin
            state     <= S_WAIT_CLOCK;
            step      <= STEP_SOFT_RESET;
            done_flag <= 1'b0;
          end
        S_WAIT_CLOCK:
          if (clock_good)
            state <= S_SEND;
        S_SEND:
        begin
          spi_start <= 1'b1;
          state     <= S_WAIT_SPI;
        end
        S_WAIT_SPI:
          if (spi_done)
          begin
            if (step == STEP_SOFT_RESET)
            begin
              state      <= S_HOLD;
              hold_count <= 8'h00;
            end
            else if (last_step)
            begin
              state     <= S_DONE;
              done_flag <= 1'b1;
            end
            else
            begin
              step  <= step + 4'h1;
              state <= S_SEND;
            end
          end
        S_HOLD:
          if (hold_over)
          begin
            step  <= step + 4'h1;
            state <= S_SEND;
          end
          else
            hold_count <= hold_count + 8'h01;
      endcase
    end
  end

  // serial port, its pins re-registered so outputs come from flops here
  spi_frame_writer #(
    .HALF_PERIOD (SPI_HALF_PERIOD),
    .FRAME_BITS  (24)
  ) writer (
    .clk   (clk),
    .reset (reset),
    .start (spi_start),
    .frame (cur_frame),
    .busy  (spi_busy),
    .done  (spi_done),
    .sclk  (sclk_int),
    .cs_n  (cs_n_int),
    .mosi  (mosi_int)
  );

  // one-cycle pin delay keeps the three pins aligned with each other
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      spi_sclk <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
    end
    else
    begin
      spi_sclk <= sclk_int;
      spi_cs_n <= cs_n_int;
      spi_mosi <= mosi_int;
    end
  end

  // the soft reset frame leaves only after the clock wait saw a stable clock
  clock_first_a: assert property (@(posedge clk) disable iff (reset)
    (spi_start && step == STEP_SOFT_RESET) |-> $past(clock_good, 2))
    else $error("soft reset frame before stable clock");

  clock_gate_a: assert property (@(posedge clk) disable iff (reset)
    ($past(state) == S_WAIT_CLOCK && state == S_SEND) |-> $past(clock_good))
    else $error("sequence left clock wait without stable clock");

  // the soft reset hold lasts the full settle time before the next frame
  reset_hold_a: assert property (@(posedge clk) disable iff (reset)
    ($past(state) == S_HOLD && state == S_SEND) |->
    $past(hold_count) == 8'(SOFT_RESET_CYCLES - 1) && step == STEP_LINK_OFF)
    else $error("soft reset hold too short");

  // link off frame carries a zero to the link enable address
  link_off_a: assert property (@(posedge clk) disable iff (reset)
    (spi_start && step == STEP_LINK_OFF) |->
    cur_frame.addr == DEV_LINK_ENABLE_ADDR && cur_frame.data == BIT_OFF)
    else $error("link off frame wrong");

  // calibration off frame carries a zero to the calibration enable address
  cal_off_a: assert property (@(posedge clk) disable iff (reset)
    (spi_start && step == STEP_CAL_OFF) |->
    cur_frame.addr == DEV_CAL_ENABLE_ADDR && cur_frame.data == BIT_OFF)
    else $error("calibration off frame wrong");

  // multiframe frame carries the software field unchanged
  multiframe_a: assert property (@(posedge clk) disable iff (reset)
    (spi_start && step == STEP_MULTIFRAME) |->
    cur_frame.data == cfg.multiframe_length_minus_one)
    else $error("multiframe value wrong");

  // link restart writes a one
  link_on_a: assert property (@(posedge clk) disable iff (reset)
    (spi_start && step == STEP_LINK_ON) |-> cur_frame.data == BIT_ON &&
    cur_frame.addr == DEV_LINK_ENABLE_ADDR) else $error("link on frame wrong");

  // trigger high frame is preceded by the trigger low frame
  trigger_edge_a: assert property (@(posedge clk) disable iff (reset)
    (spi_start && step == STEP_TRIG_HIGH) |-> cur_frame.data == BIT_ON &&
    $past(step, 2) == STEP_TRIG_LOW) else $error("trigger not zero then one");

  // steps advance by exactly one, or restart at the soft reset
  step_order_a: assert property (@(posedge clk) disable iff (reset)
    (step != $past(step)) |-> (step == $past(step) + 4'h1) || (step == STEP_SOFT_RESET))
    else $error("step order broken");

  // no new frame while one is in flight
  one_frame_a: assert property (@(posedge clk) disable iff (reset)
    spi_start |-> !spi_busy) else $error("frame started while busy");

  // core regulator comes on only while 1.9 V is good
  core_after_a: assert property (@(posedge clk) disable iff (reset)
    $rose(core_1v1_rails_enable) |-> $past(analog_good))
    else $error("core enabled without 1.9 V good");

  // loss of 1.9 V pulls the core enable within the sync delay
  core_drop_a: assert property (@(posedge clk) disable iff (reset)
    (!analog_1v9_rail_good) [*4] |-> !core_1v1_rails_enable)
    else $error("core stayed on after 1.9 V loss");

endmodule // converter_startup_sequencer

//--- converter_device_model.sv
// behavioural converter on the write-only serial register port
// assumes mode 0 frames of 24 bits, msb first, read flag in bit 23
`timescale 1ns/1ps

module converter_device_model
  import converter_startup_pkg::*;
(
  input wire logic clk,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic rx_sync_request
);
  logic [23:0] shift;
  logic [23:0] got[$];
  int          starts[$];
  int          ends[$];
  int          cyc;
  int          cal_runs;
  int          order_err;
  logic        link_on;
  logic        cal_on;
  logic        mode_done;
  logic [7:0]  mf_len;
  logic        link_up;
  logic [7:0]  trig;

  // both machines run at power-up and the trigger sits high, the awkward start
  initial
  begin
    shift = 24'h0;
    cyc = 0;
    cal_runs = 0;
    order_err = 0;
    link_on = 1'h1;
    cal_on = 1'h1;
    mode_done = 1'h0;
    mf_len = 8'h0;
    link_up = 1'h0;
    trig = 8'h01;
  end

  // cycle stamps let the bench measure the settle gap between frames
  always @(posedge clk) cyc <= cyc + 1;
  // a restarted link only runs once the receiver raises its sync request
  always @(posedge clk) link_up <= link_on && rx_sync_request;
  always @(negedge cs_n) starts.push_back(cyc);
  always @(posedge sclk) if (!cs_n) shift <= {shift[22:0], mosi};

  // a frame counts only once its chip select closes; x to 1 at start is skipped
  always @(posedge cs_n)
  begin
    if (starts.size() > ends.size())
    begin
      ends.push_back(cyc);
      got.push_back(shift);
      if (shift[23]) order_err++;
      case (shift[22:8])
        DEV_SOFT_RESET_ADDR: mode_done = 1'h0;
        DEV_LINK_ENABLE_ADDR: link_on = shift[0];
        DEV_CAL_ENABLE_ADDR: cal_on = shift[0];
        DEV_LINK_MODE_ADDR:
        begin
          if (link_on || cal_on) order_err++;
          mode_done = 1'h1;
        end
        DEV_MULTIFRAME_ADDR:
        begin
          if (link_on || cal_on || !mode_done) order_err++;
          mf_len = shift[7:0];
        end
        DEV_SYNC_SOURCE_ADDR: if (link_on || cal_on) order_err++;
        DEV_CAL_CONFIG_ADDR: if (cal_on) order_err++;
        DEV_OVERRANGE_ADDR: if (!cal_on || link_on) order_err++;
        DEV_CAL_TRIGGER_ADDR:
        begin
          if (!link_on) order_err++;
          if (!trig[0] && shift[0]) cal_runs++;
          trig = shift[7:0];
        end
        default: order_err++;
      endcase
    end
  end
endmodule // converter_device_model

//--- converter_startup_sequencer_tb_top.sv
// testbench: apb software side, device model on the serial port, rails driven here
// assumes the frame order of the startup sequence; bus waits end only by the watchdog
`timescale 1ns/1ps

module converter_startup_sequencer_tb_top
  import converter_startup_pkg::*;
;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        a19_good;
  logic        core_good;
  logic        clk_stable;
  logic        a19_en;
  logic        core_en;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic [31:0] rd;
  logic        er;
  logic [31:0] cfg;
  logic [14:0] exp_a[12];
  logic [7:0]  exp_d[12];
  logic        rx_sync;
  int          n_errors;
  int          checked;
  int          i;

  initial clk = 1'h0;
  always #4 clk = ~clk;
  // the core regulator reports good one cycle after it is enabled
  always @(posedge clk) core_good <= core_en;

  converter_startup_sequencer DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analog_1v9_rail_good(a19_good), .core_1v1_rails_good(core_good),
    .device_clock_stable(clk_stable), .analog_1v9_rail_enable(a19_en),
    .core_1v1_rails_enable(core_en), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi));

  converter_device_model dev (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .rx_sync_request(rx_sync));

  task chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask

  // one apb transfer; entered just after a rising edge, waits for pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task close_out();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a full sequence needs about 2500 cycles; the limit leaves wide margin
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("[ERR] %0t watchdog ran out", $time);
    close_out();
  end

  initial
  begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    a19_good = 1'h0;
    rx_sync = 1'h0;
    clk_stable = 1'h0;
    n_errors = 0;
    checked = 0;
    void'($urandom(9));
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    // reset values and an unmapped offset
    apb(1'h0, CONFIG_OFFSET, 32'h0);
    chk(rd, {9'h0, CONFIG_RESET});
    apb(1'h0, CONTROL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 8'h0C, 32'hFFFFFFFF);
    chk(er, 1'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'h1);
    $display("test registers done");
    // core rail waits for the analog rail
    apb(1'h1, CONTROL_OFFSET, 32'h1);
    repeat (20) @(posedge clk);
    chk({a19_en, core_en}, 2'h2);
    a19_good <= 1'h1;
    repeat (6) @(posedge clk);
    chk(core_en, 1'h1);
    $display("test power up done");
    // random settings, then start while the device clock is not yet stable
    cfg = $urandom & 32'h007FFFFF;
    apb(1'h1, CONFIG_OFFSET, cfg);
    apb(1'h0, CONFIG_OFFSET, 32'h0);
    chk(rd, cfg);
    apb(1'h1, CONTROL_OFFSET, 32'h3);
    repeat (300) @(posedge clk);
    chk(dev.got.size(), 0);
    apb(1'h1, CONFIG_OFFSET, ~cfg & 32'h007FFFFF);
    clk_stable <= 1'h1;
    i = 0;
    do
    begin
      apb(1'h0, STATUS_OFFSET, 32'h0);
      i++;
    end
    while (rd[1] !== 1'h1 && i < 2000);
    chk(rd[1], 1'h1);
    apb(1'h0, CONFIG_OFFSET, 32'h0);
    chk(rd, cfg);
    // expected frame list; field bytes follow the config register layout
    exp_a = '{DEV_SOFT_RESET_ADDR, DEV_LINK_ENABLE_ADDR, DEV_CAL_ENABLE_ADDR,
      DEV_LINK_MODE_ADDR, DEV_MULTIFRAME_ADDR, DEV_SYNC_SOURCE_ADDR, DEV_CAL_CONFIG_ADDR,
      DEV_CAL_ENABLE_ADDR, DEV_OVERRANGE_ADDR, DEV_LINK_ENABLE_ADDR, DEV_CAL_TRIGGER_ADDR,
      DEV_CAL_TRIGGER_ADDR};
    exp_d = '{SOFT_RESET_DATA, BIT_OFF, BIT_OFF, {3'h0, cfg[4:0]}, cfg[15:8],
      {7'h0, cfg[16]}, {6'h0, cfg[18:17]}, BIT_ON, {4'h0, cfg[22:19]}, BIT_ON, BIT_OFF,
      BIT_ON};
    chk(dev.got.size(), 12);
    for (i = 0; i < 12 && i < dev.got.size(); i++)
    begin
      chk(dev.got[i][22:8], exp_a[i]);
      chk(dev.got[i][7:0], exp_d[i]);
      chk(dev.got[i][23], 1'h0);
    end
    chk(dev.starts[1] - dev.ends[0] >= 125, 1'h1);
    chk({dev.link_on, dev.cal_on, dev.mf_len}, {2'h3, cfg[15:8]});
    chk(dev.cal_runs, 1);
    chk(dev.order_err, 0);
    // the restarted link waits for the receiver's sync request
    chk(dev.link_up, 1'h0);
    rx_sync <= 1'h1;
    repeat (2) @(posedge clk);
    chk(dev.link_up, 1'h1);
    $display("test sequence done");
    // analog rail drops out: core rail must follow within the sync latency
    a19_good <= 1'h0;
    repeat (4) @(posedge clk);
    chk(core_en, 1'h0);
    a19_good <= 1'h1;
    repeat (6) @(posedge clk);
    chk(core_en, 1'h1);
    $display("test power loss done");
    close_out();
  end
endmodule // converter_startup_sequencer_tb_top
